// ---- core/cawr_consts.vh ----
// Register map, field positions and reset values of the acquisition window block
`ifndef CAWR_CONSTS_VH
`define CAWR_CONSTS_VH

// Register byte offsets
`define CAWR_OFF_CTRL 8'h00
`define CAWR_OFF_FRAMES 8'h04
`define CAWR_OFF_WIN_H 8'h08
`define CAWR_OFF_WIN_V 8'h0c
`define CAWR_OFF_ROI_H 8'h10
`define CAWR_OFF_ROI_V 8'h14
`define CAWR_OFF_TRIG 8'h18
`define CAWR_OFF_TDIO 8'h1c
`define CAWR_OFF_PG_HIGH 8'h20
`define CAWR_OFF_PG_PERIOD 8'h24
`define CAWR_OFF_PG_CTRL 8'h28
`define CAWR_OFF_STATUS 8'h2c

// Field positions
`define CAWR_CTRL_START 0
`define CAWR_CTRL_ABORT 1
`define CAWR_CTRL_CCSEL_LO 4
`define CAWR_PG_GO 16
`define CAWR_PG_ROUTE 17
`define CAWR_PG_LINE_LO 18
`define CAWR_ST_OVF 3

// Reset values
`define CAWR_RST_FRAMES 16'h0001
`define CAWR_RST_START 16'h0000
`define CAWR_RST_COUNT 16'hffff
`define CAWR_RST_PG_HIGH 16'h0001
`define CAWR_RST_PG_PERIOD 16'h0002

`endif

// ---- core/cawr_fifo.v ----
// Small synchronous FIFO with registered read side
`default_nettype none

module cawr_fifo #(
    parameter WIDTH = 25,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Fill side
    input wire wr_valid,
    input wire [WIDTH-1:0] wr_data,
    output wire wr_ready,
    // Drain side
    output reg rd_valid,
    output reg [WIDTH-1:0] rd_data,
    input wire rd_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // Full stalls the writer; pop refills the output register
    assign wr_ready = (count != DEPTH[AW:0]);
    assign push = wr_valid & wr_ready;
    assign pop = (count != {(AW+1){1'b0}}) & (~rd_valid | rd_ready);

    // Storage array has no reset; pointers, level and output register do
    always @(posedge pclk) begin
        if (push) begin
            mem[wptr] <= wr_data;
        end
    end

    // Pointers, level and output register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            rd_valid <= 1'b0;
            rd_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
                rd_data <= mem[rptr];
                rd_valid <= 1'b1;
            end else if (rd_ready) begin
                rd_valid <= 1'b0;
                rd_data <= {WIDTH{1'b0}};
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule // cawr_fifo

`default_nettype wire

// ---- core/cawr_top.v ----
// Camera port acquisition window, region of interest, start and trigger control
// Function
// R1 - Horizontal window: first pixel and pixel count from line-valid assertion.
// R2 - Vertical window: first line and line count from frame-valid assertion.
// R3 - Nested pixel/line start and count define region of interest in window.
// R4 - Only pixels inside region of interest are stored.
// R5 - Only qualified pixels are forwarded to the tap formatter stage.
// R6 - Region selection applies on every line and every frame acquired.
// R7 - Software start with programmable frame count, single or finite sequence.
// R8 - Enabled trigger line, external or bus, may start acquisition.
// R9 - Each trigger input selects rising or falling starting edge.
// R10 - Per-port counter pulse generator makes single pulses or pulse trains.
// R11 - Pulse output routable to a selected trigger line driving camera control.
// R12 - Selected pixels handed to host transfer logic for system memory.
// R13 - Trigger lines shared by ports; latest assignment from either wins.
// R14 - Each trigger line drivable asserted or deasserted as digital output.
// R15 - Counters restart on line/frame valid; qualify stops at programmed count.
//
// The address map and the APB slave port were decided locally.
`include "cawr_consts.vh"
`default_nettype none

module cawr_top #(
    parameter NTRIG = 8,
    parameter DW = 24,
    parameter FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Camera link side
    input wire cam_clk,
    input wire cam_fval,
    input wire cam_lval,
    input wire [DW-1:0] cam_data,
    output reg cam_ctrl,
    // Shared trigger lines
    input wire [NTRIG-1:0] trig_in,
    output reg [NTRIG-1:0] trig_out,
    output reg [NTRIG-1:0] trig_oe_n,
    // Assignments from the peer port
    input wire peer_set,
    input wire [2:0] peer_line,
    input wire peer_level,
    input wire peer_drive,
    // Pixel stream to host transfer logic
    output wire px_valid,
    output wire [DW-1:0] px_data,
    output wire px_first,
    input wire px_ready
);

    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_CAPT = 2'b10;

    // Configuration and status registers
    reg [2:0] ccsel;
    reg [15:0] frames;
    reg [15:0] wh_start, wh_cnt, wv_start, wv_cnt;
    reg [15:0] rh_start, rh_cnt, rv_start, rv_cnt;
    reg [NTRIG-1:0] trig_en, trig_fall, line_lvl, line_drv;
    reg [15:0] pg_high, pg_period, pg_count;
    reg pg_route;
    reg [2:0] pg_line;
    reg ovf;
    reg [15:0] frames_done;
    reg [1:0] state;

    // Synchronisers and sampled video
    reg s1_clk, s2_clk, clk_d;
    reg s1_fv, s2_fv, s1_lv, s2_lv;
    reg [DW-1:0] s1_dat, s2_dat;
    reg [NTRIG-1:0] s1_trg, s2_trg, trg_d;
    reg fval_q, lval_q;
    reg [15:0] pix_cnt, line_cnt, frames_left;
    reg first_pend;

    // Pulse generator
    reg [15:0] pg_cyc, pg_left;
    reg pg_run, pulse;

    wire wr_en = psel & penable & pready & pwrite;
    wire rd_en = psel & penable & ~pready;
    wire sw_start = wr_en & (paddr == `CAWR_OFF_CTRL) & pwdata[`CAWR_CTRL_START];
    wire sw_abort = wr_en & (paddr == `CAWR_OFF_CTRL) & pwdata[`CAWR_CTRL_ABORT];
    wire pg_go = wr_en & (paddr == `CAWR_OFF_PG_CTRL) & pwdata[`CAWR_PG_GO];

    // Window or region hit: index inside [start, start+count)
    function hit;
        input [15:0] idx, start, cnt;
        reg [15:0] rel;
        begin
            rel = idx - start;
            hit = (idx >= start) && (rel < cnt);
        end
    endfunction

    // Link clock, enables, data and triggers all cross into pclk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {s1_clk, s2_clk, clk_d, s1_fv, s2_fv, s1_lv, s2_lv} <= 7'h00;
            s1_dat <= {DW{1'b0}};
            s2_dat <= {DW{1'b0}};
            s1_trg <= {NTRIG{1'b0}};
            s2_trg <= {NTRIG{1'b0}};
            trg_d <= {NTRIG{1'b0}};
        end else begin
            s1_clk <= cam_clk;
            s2_clk <= s1_clk;
            clk_d <= s2_clk;
            s1_fv <= cam_fval;
            s2_fv <= s1_fv;
            s1_lv <= cam_lval;
            s2_lv <= s1_lv;
            s1_dat <= cam_data;
            s2_dat <= s1_dat;
            s1_trg <= trig_in;
            s2_trg <= s1_trg;
            trg_d <= s2_trg;
        end
    end

    // Pixel strobe on each rising edge of the camera clock
    wire px_stb = s2_clk & ~clk_d;
    wire fv_rise = s2_fv & ~fval_q;
    wire fv_fall = ~s2_fv & fval_q;
    wire lv_rise = s2_lv & ~lval_q;
    wire [15:0] pix_idx = lv_rise ? 16'h0000 : pix_cnt; // R15
    wire [15:0] line_idx = fv_rise ? 16'h0000 : line_cnt; // R15

    // Selected edge on any enabled trigger input
    wire [NTRIG-1:0] trg_hit;
    genvar g;
    generate
        for (g = 0; g < NTRIG; g = g + 1) begin : g_trg
            assign trg_hit[g] = trig_en[g] & (trig_fall[g] ? (trg_d[g] & ~s2_trg[g]) // R9
                : (~trg_d[g] & s2_trg[g]));
        end
    endgenerate
    wire trig_start = |trg_hit; // R8

    // Pixel qualification: window, then nested region inside it
    wire in_win = hit(pix_idx, wh_start, wh_cnt) & hit(line_idx, wv_start, wv_cnt); // R1 R2
    wire in_roi = hit(pix_idx - wh_start, rh_start, rh_cnt) // R3
        & hit(line_idx - wv_start, rv_start, rv_cnt);
    wire capt_now = (state == ST_CAPT) | ((state == ST_WAIT) & fv_rise);
    wire qual = px_stb & capt_now & s2_fv & s2_lv & in_win & in_roi; // R4 R5 R6
    wire fifo_ready;

    // Camera cannot be stalled: a full FIFO drops and flags overflow
    cawr_fifo #(
        .WIDTH(DW + 1),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .wr_valid(qual),
        .wr_data({first_pend, s2_dat}),
        .wr_ready(fifo_ready),
        .rd_valid(px_valid),
        .rd_data({px_first, px_data}),
        .rd_ready(px_ready)
    ); // R12

    // Pixel and line counters, reloaded on every valid assertion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fval_q <= 1'b0;
            lval_q <= 1'b0;
            pix_cnt <= 16'h0000;
            line_cnt <= 16'h0000;
        end else if (px_stb) begin
            fval_q <= s2_fv;
            lval_q <= s2_lv;
            if (s2_lv && pix_idx != 16'hffff) begin
                pix_cnt <= pix_idx + 16'h0001; // R15
            end
            if (fv_rise) begin
                line_cnt <= 16'h0000; // R15
            end else if (lval_q && !s2_lv && s2_fv && line_cnt != 16'hffff) begin
                line_cnt <= line_cnt + 16'h0001;
            end
        end
    end

    // Acquisition sequencer: software or trigger start, frame count with zero meaning endless
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            frames_left <= 16'h0000;
            frames_done <= 16'h0000;
            first_pend <= 1'b0;
        end else begin
            if (qual) begin
                first_pend <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (sw_start || trig_start) begin // R7 R8
                        state <= ST_WAIT;
                        frames_left <= frames;
                        frames_done <= 16'h0000;
                    end
                end
                ST_WAIT: begin
                    if (sw_abort) begin
                        state <= ST_IDLE;
                    end else if (px_stb && fv_rise) begin
                        state <= ST_CAPT;
                        first_pend <= ~qual;
                    end
                end
                ST_CAPT: begin
                    if (sw_abort) begin
                        state <= ST_IDLE;
                    end else if (px_stb && fv_fall) begin
                        frames_done <= frames_done + 16'h0001;
                        if (frames_left == 16'h0001) begin // R7
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_WAIT;
                            if (frames_left != 16'h0000) begin
                                frames_left <= frames_left - 16'h0001;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Pulse generator: high for pg_high cycles of every pg_period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_run <= 1'b0;
            pg_cyc <= 16'h0000;
            pg_left <= 16'h0000;
            pulse <= 1'b0;
        end else if (pg_go) begin
            pg_run <= 1'b1; // R10
            pg_cyc <= 16'h0000;
            pg_left <= pwdata[15:0];
            pulse <= 1'b1;
        end else if (pg_run) begin
            if (pg_cyc + 16'h0001 >= pg_period) begin
                pg_cyc <= 16'h0000;
                // Count of zero means an endless train
                if (pg_left == 16'h0001) begin
                    pg_run <= 1'b0;
                    pg_left <= 16'h0000;
                    pulse <= 1'b0;
                end else begin
                    pulse <= 1'b1;
                    if (pg_left != 16'h0000) begin
                        pg_left <= pg_left - 16'h0001;
                    end
                end
            end else begin
                pg_cyc <= pg_cyc + 16'h0001;
                pulse <= (pg_cyc + 16'h0001 < pg_high); // R10
            end
        end else begin
            pulse <= 1'b0;
        end
    end

    // Register writes; peer assignment after ours so the latest one wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccsel <= 3'h0;
            frames <= `CAWR_RST_FRAMES;
            wh_start <= `CAWR_RST_START;
            wh_cnt <= `CAWR_RST_COUNT;
            wv_start <= `CAWR_RST_START;
            wv_cnt <= `CAWR_RST_COUNT;
            rh_start <= `CAWR_RST_START;
            rh_cnt <= `CAWR_RST_COUNT;
            rv_start <= `CAWR_RST_START;
            rv_cnt <= `CAWR_RST_COUNT;
            trig_en <= {NTRIG{1'b0}};
            trig_fall <= {NTRIG{1'b0}};
            line_lvl <= {NTRIG{1'b0}};
            line_drv <= {NTRIG{1'b0}};
            pg_high <= `CAWR_RST_PG_HIGH;
            pg_period <= `CAWR_RST_PG_PERIOD;
            pg_route <= 1'b0;
            pg_line <= 3'h0;
            ovf <= 1'b0;
        end else begin
            if (wr_en) begin
                case (paddr)
                    `CAWR_OFF_CTRL: ccsel <= pwdata[`CAWR_CTRL_CCSEL_LO +: 3];
                    `CAWR_OFF_FRAMES: frames <= pwdata[15:0];
                    `CAWR_OFF_WIN_H: {wh_cnt, wh_start} <= pwdata; // R1
                    `CAWR_OFF_WIN_V: {wv_cnt, wv_start} <= pwdata; // R2
                    `CAWR_OFF_ROI_H: {rh_cnt, rh_start} <= pwdata; // R3
                    `CAWR_OFF_ROI_V: {rv_cnt, rv_start} <= pwdata; // R3
                    `CAWR_OFF_TRIG: {trig_fall, trig_en} <= pwdata[15:0]; // R9
                    `CAWR_OFF_TDIO: {line_drv, line_lvl} <= pwdata[15:0]; // R14
                    `CAWR_OFF_PG_HIGH: pg_high <= pwdata[15:0];
                    `CAWR_OFF_PG_PERIOD: pg_period <= pwdata[15:0];
                    `CAWR_OFF_PG_CTRL: begin
                        pg_route <= pwdata[`CAWR_PG_ROUTE]; // R11
                        pg_line <= pwdata[`CAWR_PG_LINE_LO +: 3];
                    end
                    `CAWR_OFF_STATUS: begin
                        if (pwdata[`CAWR_ST_OVF]) begin
                            ovf <= 1'b0;
                        end
                    end
                    default: ovf <= ovf;
                endcase
            end
            if (peer_set) begin
                line_lvl[peer_line] <= peer_level; // R13
                line_drv[peer_line] <= peer_drive; // R13
            end
            // Drop on a full FIFO beats a clear in the same cycle
            if (qual && !fifo_ready) begin
                ovf <= 1'b1;
            end
        end
    end

    // Line drivers: routed pulse overrides the static level of its line
    reg [NTRIG-1:0] next_trig_out, next_trig_oe_n;
    integer i;
    always @* begin
        for (i = 0; i < NTRIG; i = i + 1) begin
            if (pg_route && pg_line == i[2:0]) begin
                next_trig_out[i] = pulse; // R11
                next_trig_oe_n[i] = 1'b0;
            end else begin
                next_trig_out[i] = line_lvl[i]; // R14
                next_trig_oe_n[i] = ~line_drv[i];
            end
        end
    end

    // Read mux; unmapped offsets answer with an error
    reg [31:0] next_rdata;
    reg next_err;
    always @* begin
        next_err = 1'b0;
        case (paddr)
            `CAWR_OFF_CTRL: next_rdata = {25'h0, ccsel, 4'h0};
            `CAWR_OFF_FRAMES: next_rdata = {16'h0, frames};
            `CAWR_OFF_WIN_H: next_rdata = {wh_cnt, wh_start};
            `CAWR_OFF_WIN_V: next_rdata = {wv_cnt, wv_start};
            `CAWR_OFF_ROI_H: next_rdata = {rh_cnt, rh_start};
            `CAWR_OFF_ROI_V: next_rdata = {rv_cnt, rv_start};
            `CAWR_OFF_TRIG: next_rdata = {16'h0, trig_fall, trig_en};
            `CAWR_OFF_TDIO: next_rdata = {8'h0, s2_trg, line_drv, line_lvl};
            `CAWR_OFF_PG_HIGH: next_rdata = {16'h0, pg_high};
            `CAWR_OFF_PG_PERIOD: next_rdata = {16'h0, pg_period};
            `CAWR_OFF_PG_CTRL: next_rdata = {11'h0, pg_line, pg_route, 1'b0, pg_left};
            `CAWR_OFF_STATUS: next_rdata = {frames_done, 12'h0, ovf, pulse, state};
            default: begin
                next_rdata = 32'h0000_0000;
                next_err = 1'b1;
            end
        endcase
    end

    // One wait state: answer registered in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            trig_out <= {NTRIG{1'b0}};
            trig_oe_n <= {NTRIG{1'b1}};
            cam_ctrl <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            if (rd_en && !pwrite) begin
                prdata <= next_rdata;
            end
            trig_out <= next_trig_out;
            trig_oe_n <= next_trig_oe_n;
            // Selected line, as driven or as seen, feeds the camera control
            cam_ctrl <= next_trig_oe_n[ccsel] ? s2_trg[ccsel] : next_trig_out[ccsel]; // R11
        end
    end

endmodule // cawr_top

`default_nettype wire

// ---- verification/cawr_cam.sv ----
// Behavioural camera sending one frame per toggle of its request
`default_nettype none
module cawr_cam (
    // Frame request
    input wire logic go,
    input wire logic [7:0] npix,
    input wire logic [7:0] nlin,
    // Camera link outputs
    output logic cam_clk,
    output logic cam_fval,
    output logic cam_lval,
    output logic [23:0] cam_data,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // One link cycle of 320 ns; data settles 80 ns before the rising edge
    task tick(input int n);
        repeat (n) begin
            #80 cam_clk = 1'b1;
            #160 cam_clk = 1'b0;
            #80;
        end
    endtask
    initial begin
        cam_clk = 1'b0;
        cam_fval = 1'b0;
        cam_lval = 1'b0;
        cam_data = 24'h0;
        busy = 1'b0;
    end
    // Clock stands still between frames; idle data is inverted so it never looks valid
    always @(go) begin
        #10 busy = 1'b1;
        cam_fval = 1'b1;
        tick(2);
        for (int l = 0; l < nlin; l++) begin
            for (int p = 0; p < npix; p++) begin
                cam_lval = 1'b1;
                cam_data = {8'h5a, l[7:0], p[7:0]};
                tick(1);
            end
            cam_lval = 1'b0;
            cam_data = ~cam_data;
            tick(2);
        end
        cam_fval = 1'b0;
        tick(2);
        busy = 1'b0;
    end
endmodule // cawr_cam
`default_nettype wire

// ---- verification/cawr_props.sv ----
// Port-level assertion checker for the acquisition window block
`default_nettype none
module cawr_props #(
    parameter NTRIG = 8,
    parameter DW = 24
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Trigger lines and peer port
    input wire logic [NTRIG-1:0] trig_out,
    input wire logic [NTRIG-1:0] trig_oe_n,
    input wire logic peer_set,
    input wire logic [2:0] peer_line,
    input wire logic peer_level,
    input wire logic peer_drive,
    // Pixel stream
    input wire logic px_valid,
    input wire logic [DW-1:0] px_data,
    input wire logic px_first,
    input wire logic px_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] held_line;
    logic held_level;
    // Peer request kept so the check survives the one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_line <= 3'h0;
            held_level <= 1'b0;
        end else if (peer_set) begin
            held_line <= peer_line;
            held_level <= peer_level;
        end
    end
    bus_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("wait state count wrong");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_unmapped_a: assert property (pready && paddr > 8'h2c |-> pslverr)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (pready && paddr <= 8'h2c && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    px_hold_a: assert property (px_valid && !px_ready |=> px_valid && $stable(px_data) && $stable(px_first))
        else $error("pixel changed while stalled");
    first_valid_a: assert property (px_first |-> px_valid)
        else $error("first flag without valid");
    peer_line_a: assert property (peer_set && peer_drive |=> ##[0:1] (!trig_oe_n[held_line] && trig_out[held_line] == held_level))
        else $error("peer assignment not applied");
    reset_idle_a: assert property ($rose(presetn) |-> trig_oe_n == {NTRIG{1'b1}} && !px_valid && !pready)
        else $error("outputs not idle after reset");
endmodule // cawr_props

bind cawr_top cawr_props #(.NTRIG(NTRIG), .DW(DW)) cawr_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .trig_out(trig_out), .trig_oe_n(trig_oe_n),
    .peer_set(peer_set), .peer_line(peer_line), .peer_level(peer_level),
    .peer_drive(peer_drive), .px_valid(px_valid), .px_data(px_data),
    .px_first(px_first), .px_ready(px_ready)
);
`default_nettype wire

// ---- verification/cawr_top_tb.sv ----
// Self-checking bench for the acquisition window block
`default_nettype none
module cawr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, cam_clk, cam_fval, cam_lval, cam_ctrl, busy, px_valid, px_first;
    logic [23:0] cam_data, px_data;
    logic [7:0] trig_in, trig_out, trig_oe_n, trig_ext = 8'h00, npix = 8'h0, nlin = 8'h0;
    logic peer_set = 1'b0, peer_level = 1'b0, peer_drive = 1'b0, px_ready = 1'b1, go = 1'b0;
    logic [2:0] peer_line = 3'h0;
    logic [24:0] got_q[$], exp_q[$];
    int err_count = 0, tests_run = 0, pg_hi = 0, cc_hi = 0;

    always #20 pclk = ~pclk;
    // Line level: driven value where the block drives, else the outside source
    assign trig_in = (~trig_oe_n & trig_out) | (trig_oe_n & trig_ext);

    cawr_top cawr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cam_clk(cam_clk), .cam_fval(cam_fval), .cam_lval(cam_lval),
        .cam_data(cam_data), .cam_ctrl(cam_ctrl), .trig_in(trig_in), .trig_out(trig_out),
        .trig_oe_n(trig_oe_n), .peer_set(peer_set), .peer_line(peer_line),
        .peer_level(peer_level), .peer_drive(peer_drive), .px_valid(px_valid),
        .px_data(px_data), .px_first(px_first), .px_ready(px_ready));
    cawr_cam cawr_cam_i (.go(go), .npix(npix), .nlin(nlin), .cam_clk(cam_clk),
        .cam_fval(cam_fval), .cam_lval(cam_lval), .cam_data(cam_data), .busy(busy));

    // Collect accepted pixels and count pulse-line high cycles
    always @(posedge pclk) begin
        if (px_valid === 1'b1 && px_ready === 1'b1) got_q.push_back({px_first, px_data});
        if (trig_out[2] === 1'b1 && trig_oe_n[2] === 1'b0) pg_hi++;
        if (cam_ctrl === 1'b1) cc_hi++;
    end

    task conclude;
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    // One bus transfer; two idle cycles after so no signal is assigned twice per step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask
    task frame(input logic [7:0] np, input logic [7:0] nl);
        npix <= np;
        nlin <= nl;
        go <= ~go;
        repeat (2) @(posedge pclk);
        while (busy) @(posedge pclk);
        repeat (30) @(posedge pclk);
    endtask

    // Hang guard, far beyond the roughly 1500 cycles the tests take
    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        conclude;
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values and a refused address
        rdc(8'h04, 32'hffffffff, 32'h1);
        rdc(8'h08, 32'hffffffff, 32'hffff0000);
        rdc(8'h14, 32'hffffffff, 32'hffff0000);
        rdc(8'h24, 32'hffffffff, 32'h2);
        apb(1'b0, 8'h30, 32'h0);
        chk({q, e}, 33'h1);
        // Nested region over two frames: lines 1..2, pixels 2..4
        wr(8'h08, 32'h00060001);
        wr(8'h0c, 32'h00030001);
        wr(8'h10, 32'h00030001);
        wr(8'h14, 32'h00020000);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h1);
        rdc(8'h2c, 32'h3, 32'h1);
        frame(8'd8, 8'd5);
        frame(8'd8, 8'd5);
        rdc(8'h2c, 32'hffffffff, 32'h00020000);
        for (int f = 0; f < 2; f++)
            for (int l = 1; l < 3; l++)
                for (int p = 2; p < 5; p++)
                    exp_q.push_back({l == 1 && p == 2, 8'h5a, l[7:0], p[7:0]});
        chk(got_q.size(), exp_q.size());
        for (int i = 0; i < exp_q.size(); i++) chk(got_q[i], exp_q[i]);
        // Full window with the host stalled: store overflows, then drain
        got_q.delete();
        for (int r = 2; r < 6; r++) wr(8'(r * 4), 32'hffff0000);
        wr(8'h04, 32'h1);
        px_ready <= 1'b0;
        wr(8'h00, 32'h1);
        frame(8'd8, 8'd3);
        rdc(8'h2c, 32'hffff0008, 32'h00010008);
        px_ready <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(got_q.size(), 32'd9);
        chk(got_q[0], 25'h15a0000);
        wr(8'h2c, 32'h8);
        rdc(8'h2c, 32'h8, 32'h0);
        // Trigger line 3, falling edge selected
        wr(8'h18, 32'h00000808);
        trig_ext[3] <= 1'b1;
        repeat (8) @(posedge pclk);
        rdc(8'h2c, 32'h3, 32'h0);
        trig_ext[3] <= 1'b0;
        repeat (8) @(posedge pclk);
        rdc(8'h2c, 32'h3, 32'h1);
        wr(8'h00, 32'h2);
        rdc(8'h2c, 32'h3, 32'h0);
        // Lines as outputs, shared with the peer port
        wr(8'h1c, 32'h00008181);
        chk({trig_oe_n, trig_out & 8'h81}, 16'h7e81);
        rdc(8'h1c, 32'hffffff, 32'h818181);
        peer_line <= 3'h7;
        peer_drive <= 1'b1;
        peer_set <= 1'b1;
        @(posedge pclk);
        peer_set <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({trig_oe_n[7], trig_out[7]}, 2'b00);
        wr(8'h1c, 32'h00008180);
        chk({trig_oe_n[7], trig_out[7]}, 2'b01);
        wr(8'h1c, 32'h0);
        chk(trig_oe_n, 8'hff);
        // Pulse train routed to line 2, which also feeds the camera control
        wr(8'h00, 32'h20);
        wr(8'h20, 32'h2);
        wr(8'h24, 32'h5);
        pg_hi = 0;
        cc_hi = 0;
        wr(8'h28, 32'h000b0003);
        repeat (40) @(posedge pclk);
        chk(pg_hi, 32'd6);
        chk(cc_hi, 32'd6);
        rdc(8'h28, 32'hffff, 32'h0);
        conclude;
    end
endmodule // cawr_top_tb
`default_nettype wire
